// *** dv/eoc_message_processor_bench.sv ***
// Purpose: Self-checking bench for eocp_top
// Assumes: Messages spaced a few cycles apart, far below 6 ms
// Notes:   Expectations follow the command codes and mode numbers
`timescale 1ns/1ps
`include "eocp_cfg.svh"
`default_nettype none
module eoc_message_processor_bench;
  import eocp_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        deactivate = 1'b0;
  logic [31:0] reg_rdata;
  logic        rx_msg_valid;
  logic [11:0] rx_msg;
  logic [11:0] tx_msg;
  logic        rx_report;
  logic [8:0]  act;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cycles = 0;

  eocp_lt_model lt_u (.rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg), .clk(clk));
  eocp_top dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_msg_valid(rx_msg_valid), .rx_msg(rx_msg), .deactivate(deactivate),
    .tx_msg(tx_msg), .rx_report(rx_report),
    .full_loopback_cmd(act[8]), .analog_loop_request_ind(act[7]),
    .bearer1_loopback(act[6]), .bearer2_loopback(act[5]),
    .loop_side_select(act[4]), .crc_invert(act[3]), .febe_count_stop(act[2]),
    .nebe_count_stop(act[1]), .err_ind_hold(act[0])
  );

  // Free-running clock
  initial
    forever #2.5 clk = ~clk;

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Register cycles; data is read in the one cycle where it stands
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // One message; answer checked in the cycle after, actions one cycle later
  task automatic msg(input logic [11:0] m, input logic [11:0] et, input logic er);
    lt_u.send(m);
    #1;
    check("tx_msg", tx_msg, et);
    check("rx_report", rx_report, er);
    @(posedge clk);
    #1;
  endtask

  task automatic t_reset();
    logic [31:0] v;
    check("tx_msg", tx_msg, 32'h1FF);
    check("actions", act, 32'h0);
    rd(8'h3C, v);
    check("unmapped", v, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_auto_cmds();
    logic [7:0]  code [6] = '{8'h00, 8'h50, 8'h51, 8'h52, 8'h53, 8'h54};
    logic [8:0]  exp [6] = '{9'h000, 9'h180, 9'h1D0, 9'h1F0, 9'h1FD, 9'h1FF};
    logic [11:0] m;
    logic [31:0] v;
    for (int i = 0; i < 6; i++)
    begin
      m = {i[0] ? 4'hF : 4'h1, code[i]};
      for (int n = 0; n < 3; n++)
        msg(m, m, n == 2);
      check("actions", act, exp[i]);
    end
    rd(`EOCP_REG_STATUS, v);
    check("status", v, 32'h1FF);
    for (int n = 0; n < 3; n++)
      msg(12'h1FF, 12'h1FF, n == 2);
    check("actions", act, 32'h0);
    $display("test auto commands done");
  endtask

  task automatic t_auto_faults();
    logic [31:0] v;
    for (int n = 0; n < 3; n++)
      msg(12'h651, 12'h100, n == 2);
    check("actions", act, 32'h0);
    for (int n = 0; n < 3; n++)
      msg(12'h122, n == 2 ? 12'h1AA : 12'h122, n == 2);
    for (int n = 0; n < 3; n++)
      msg(12'h051, n == 2 ? 12'h1AA : 12'h051, n == 2);
    rd(`EOCP_REG_RX, v);
    check("received", v, 32'h051);
    for (int n = 0; n < 3; n++)
      msg(12'h152, 12'h152, n == 2);
    check("actions", act, 32'h030);
    @(posedge clk);
    deactivate <= 1'b1;
    @(posedge clk);
    deactivate <= 1'b0;
    #1;
    check("actions", act, 32'h0);
    $display("test auto faults done");
  endtask

  task automatic t_transparent();
    logic [31:0] v;
    wr(`EOCP_REG_MODE, 32'h1);
    wr(`EOCP_REG_TX, 32'h123);
    check("tx_msg", tx_msg, 32'h123);
    for (int n = 0; n < 3; n++)
      msg(12'h151, 12'h123, 1'b1);
    check("actions", act, 32'h0);
    wr(`EOCP_REG_MODE, 32'h2);
    msg(12'h152, 12'h123, 1'b1);
    msg(12'h152, 12'h123, 1'b0);
    msg(12'h153, 12'h123, 1'b1);
    wr(`EOCP_REG_MODE, 32'h3);
    for (int n = 0; n < 4; n++)
      msg(12'h154, 12'h123, n == 2);
    msg(12'h155, 12'h123, 1'b0);
    check("actions", act, 32'h0);
    rd(`EOCP_REG_VERIFIED, v);
    check("verified", v, 32'h154);
    rd(`EOCP_REG_MODE, v);
    check("mode", v, 32'h3);
    rd(`EOCP_REG_TX, v);
    check("transmit", v, 32'h123);
    $display("test transparent done");
  endtask

  // Main sequence after four cycles of reset
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_auto_cmds();
    t_auto_faults();
    t_transparent();
    print_verdict();
  end

  // Hang guard, far above the roughly 160 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
endmodule
`default_nettype wire

// *** dv/eocp_lt_model.sv ***
// Purpose: Exchange-side source of received maintenance messages
// Assumes: The caller spaces the messages
// Notes:   Between messages the bus shows the inverse of the last word
`timescale 1ns/1ps
`default_nettype none
module eocp_lt_model (
  output logic        rx_msg_valid,
  output logic [11:0] rx_msg,
  input  wire logic   clk
);
  initial
  begin
    rx_msg_valid = 1'b0;
    rx_msg       = 12'h000;
  end
  // One whole word: address, indicator, information; stale data is scrambled
  task automatic send(input logic [11:0] m);
    @(posedge clk);
    rx_msg_valid <= 1'b1;
    rx_msg       <= m;
    @(posedge clk);
    rx_msg_valid <= 1'b0;
    rx_msg       <= ~m;
  endtask
endmodule
`default_nettype wire

// *** dv/eocp_top_checker.sv ***
// Purpose: Port-level assertions for eocp_top
// Assumes: Mode is mirrored from writes seen on the register port
// Notes:   Bound to every eocp_top instance
`timescale 1ns/1ps
`include "eocp_cfg.svh"
`default_nettype none
module eocp_top_checker
  import eocp_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_msg_valid,
  input wire logic [11:0] rx_msg,
  input wire logic        deactivate,
  input wire logic [11:0] tx_msg,
  input wire logic        rx_report,
  input wire logic        full_loopback_cmd,
  input wire logic        bearer1_loopback,
  input wire logic        bearer2_loopback,
  input wire logic        loop_side_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  eocp_mode_t  mode_q;
  wire         auto = (mode_q == EOCP_AUTO);
  wire         good = (rx_msg[11:9] == 3'h0) || (rx_msg[11:9] == 3'h7);
  wire  [11:0] wlo  = reg_wdata[11:0];
  // Mode mirror; the checker cannot see the register, so it follows the writes
  always_ff @(posedge clk)
    if (rst)
      mode_q <= EOCP_AUTO;
    else if (reg_wr && reg_addr == `EOCP_REG_MODE)
      mode_q <= eocp_mode_t'(reg_wdata[1:0]);

  chk_report_cause: assert property (rx_report |-> $past(rx_msg_valid))
    else $error("report without a received message");
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_bad_addr_hold: assert property (auto && rx_msg_valid && !good |=> tx_msg == 12'h100)
    else $error("foreign address not answered with hold");
  chk_echo_auto: assert property (auto && rx_msg_valid && good && rx_msg[8] && rx_msg[7:4] == 4'h5
    && rx_msg[3:0] <= 4'h4 |=> tx_msg == $past(rx_msg))
    else $error("command not echoed");
  chk_exec_auto_only: assert property ($rose(bearer1_loopback) || $rose(full_loopback_cmd)
    |-> $past(rx_msg_valid, 2) && $past(mode_q, 2) == EOCP_AUTO)
    else $error("command executed outside auto mode");
  chk_transp_tx: assert property (!auto && reg_wr && reg_addr == `EOCP_REG_TX |=> tx_msg == $past(wlo))
    else $error("transmit code differs from written value");
  chk_side_with_b1: assert property ($rose(bearer1_loopback) |-> loop_side_select)
    else $error("bearer loop without side select");
  chk_deact_clear: assert property (deactivate |=> !(full_loopback_cmd || bearer1_loopback
    || bearer2_loopback || loop_side_select))
    else $error("deactivation left commands latched");
  chk_periodic_rep: assert property (mode_q == EOCP_PERIODIC && rx_msg_valid |=> rx_report)
    else $error("periodic report missing");

  cover property (rx_report && mode_q == EOCP_THREELOOK);
  cover property ($rose(full_loopback_cmd));
  cover property (deactivate && bearer2_loopback);
endmodule
bind eocp_top eocp_top_checker chk_u (.*);
`default_nettype wire

// *** rtl/eocp_cfg.svh ***
// Purpose: Constants for the embedded-operations-channel message processor
// Assumes: One 12-bit message is delivered by the deframer every 6 ms
// Notes:   Offsets are byte addresses on the plain register port
`ifndef EOCP_CFG_SVH
`define EOCP_CFG_SVH

// Register byte offsets
`define EOCP_REG_MODE      8'h00
`define EOCP_REG_TX        8'h04
`define EOCP_REG_RX        8'h08
`define EOCP_REG_VERIFIED  8'h0C
`define EOCP_REG_STATUS    8'h10

// Message field positions
`define EOCP_ADDR_MSB      11
`define EOCP_ADDR_LSB      9
`define EOCP_DM_BIT        8
`define EOCP_INFO_MSB      7

// Addresses
`define EOCP_ADDR_NT       3'h0
`define EOCP_ADDR_BCAST    3'h7

// Information codes
`define EOCP_CMD_HOLD      8'h00
`define EOCP_CMD_FULL      8'h50
`define EOCP_CMD_B1        8'h51
`define EOCP_CMD_B2        8'h52
`define EOCP_CMD_CRC_REQ   8'h53
`define EOCP_CMD_CRC_NOTE  8'h54
`define EOCP_CMD_NO_COMPLY 8'hAA
`define EOCP_CMD_NORMAL    8'hFF

// Reset value, fixed answers and counts
`define EOCP_TX_RESET      12'h1FF
`define EOCP_HOLD_MSG      12'h100
`define EOCP_NO_COMPLY_MSG 12'h1AA
`define EOCP_LOOKS_PRIOR   2'h2
`define EOCP_DM0_LIMIT     2'h3

`endif

// *** rtl/eocp_cmd_latch.sv ***
// Purpose: Latches executed maintenance commands until released
// Assumes: exec is a one-cycle pulse carrying a verified, addressed command
// Notes:   Release by return-to-normal or deactivation wins over a new command
`timescale 1ns/1ps
`include "eocp_cfg.svh"
`default_nettype none
module eocp_cmd_latch
  import eocp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       exec,
  input  wire logic [7:0] info,
  input  wire logic       analog_en,
  input  wire logic       deactivate,
  output eocp_latch_t     state
);

  eocp_latch_t q;
  eocp_latch_t d;

  assign state = q;

  // Commands accumulate so several tests run together
  always_comb
  begin
    d = q;
    if (exec)
    begin
      unique case (info)
        `EOCP_CMD_FULL:
        begin
          d.full_loop = 1'b1;
          d.analog_req = analog_en;
        end
        `EOCP_CMD_B1:
        begin
          d.b1       = 1'b1;
          d.side_sel = 1'b1;
        end
        `EOCP_CMD_B2:
        begin
          d.b2       = 1'b1;
          d.side_sel = 1'b1;
        end
        `EOCP_CMD_CRC_REQ:
        begin
          d.crc_inv   = 1'b1;
          d.febe_stop = 1'b1;
          d.err_hold  = 1'b1;
        end
        `EOCP_CMD_CRC_NOTE:
        begin
          d.nebe_stop = 1'b1;
          d.err_hold  = 1'b1;
        end
        `EOCP_CMD_NORMAL:
          d = '0;
        default:
          d = q;                         // Hold and others change nothing
      endcase
    end
    if (deactivate)
      d = '0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

endmodule
`default_nettype wire

// *** rtl/eocp_pkg.sv ***
// Purpose: Types for the embedded-operations-channel message processor
// Assumes: Shared by the top and its two leaf modules
// Notes:   Mode order matches the two-bit filter configuration field
`default_nettype none
package eocp_pkg;

  typedef enum logic [1:0] {
    EOCP_AUTO,
    EOCP_PERIODIC,
    EOCP_ONCHANGE,
    EOCP_THREELOOK
  } eocp_mode_t;

  typedef struct packed {
    logic [11:0] cand;
    logic [1:0]  cnt;
    logic [11:0] last_ver;
    logic        ver_valid;
  } eocp_look_t;

  typedef struct packed {
    logic full_loop;
    logic analog_req;
    logic b1;
    logic b2;
    logic side_sel;
    logic crc_inv;
    logic febe_stop;
    logic nebe_stop;
    logic err_hold;
  } eocp_latch_t;

  typedef struct packed {
    eocp_mode_t  mode;
    logic [11:0] tx;
    logic [11:0] rx;
    logic        rx_seen;
    logic [1:0]  dm0_cnt;
    logic        report;
    logic        exec;
    logic [7:0]  exec_info;
    logic        exec_analog;
    logic [31:0] rdata;
  } eocp_top_t;

endpackage
`default_nettype wire

// *** rtl/eocp_three_look.sv ***
// Purpose: Three-look verification of received messages
// Assumes: msg_valid is one cycle per received message
// Notes:   qualify and qualify_new are combinational on the cycle of msg_valid; verified comes from a register
`timescale 1ns/1ps
`include "eocp_cfg.svh"
`default_nettype none
module eocp_three_look
  import eocp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        msg_valid,
  input  wire logic [11:0] msg,
  output logic             qualify,
  output logic             qualify_new,
  output logic [11:0]      verified
);

  eocp_look_t q;
  eocp_look_t d;
  logic       same;

  assign same     = (msg == q.cand);
  assign verified = q.last_ver;

  // Third equal look qualifies; count saturates so it fires only once
  always_comb
  begin
    d           = q;
    qualify     = msg_valid && same && (q.cnt == `EOCP_LOOKS_PRIOR);
    qualify_new = qualify && (!q.ver_valid || (msg != q.last_ver));
    if (msg_valid)
    begin
      if (!same)
      begin
        d.cand = msg;
        d.cnt  = 2'h1;
      end
      else if (q.cnt != 2'h3)
      begin
        d.cnt = q.cnt + 2'h1;
      end
      if (qualify)
      begin
        d.last_ver  = msg;
        d.ver_valid = 1'b1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end

endmodule
`default_nettype wire

// *** rtl/eocp_top.sv ***
// Purpose: Embedded-operations-channel processor of a line termination's NT
// Assumes: rx_msg_valid pulses once per received message, every 6 ms
// Notes:   tx_msg holds the message the framer inserts into the next slot
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "eocp_cfg.svh"
`default_nettype none
module eocp_top
  import eocp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Link side
  input  wire logic        rx_msg_valid,
  input  wire logic [11:0] rx_msg,
  input  wire logic        deactivate,
  output logic [11:0]      tx_msg,
  output logic             rx_report,
  // Test actions
  output logic             full_loopback_cmd,
  output logic             analog_loop_request_ind,
  output logic             bearer1_loopback,
  output logic             bearer2_loopback,
  output logic             loop_side_select,
  output logic             crc_invert,
  output logic             febe_count_stop,
  output logic             nebe_count_stop,
  output logic             err_ind_hold
);

  eocp_top_t   q;
  eocp_top_t   d;
  eocp_latch_t latch;

  logic        look_ok;
  logic        look_new;
  logic [11:0] verified;

  // Message fields
  logic [2:0]  rx_addr;
  logic        rx_dm;
  logic [7:0]  rx_info;
  logic        addr_ok;
  logic        defined;
  logic        is_auto;
  logic        sw_tx_wr;
  logic [1:0]  dm0_next;

  assign rx_addr = rx_msg[`EOCP_ADDR_MSB:`EOCP_ADDR_LSB];
  assign rx_dm   = rx_msg[`EOCP_DM_BIT];
  assign rx_info = rx_msg[`EOCP_INFO_MSB:0];
  assign addr_ok = (rx_addr == `EOCP_ADDR_NT) || (rx_addr == `EOCP_ADDR_BCAST);
  assign is_auto = (q.mode == EOCP_AUTO);
  assign sw_tx_wr = reg_wr && (reg_addr == `EOCP_REG_TX);

  // Supported command set; in auto mode any other addressed message with the indicator set earns unable-to-comply on its third equal look
  always_comb
  begin
    unique case (rx_info)
      `EOCP_CMD_HOLD,
      `EOCP_CMD_FULL,
      `EOCP_CMD_B1,
      `EOCP_CMD_B2,
      `EOCP_CMD_CRC_REQ,
      `EOCP_CMD_CRC_NOTE,
      `EOCP_CMD_NORMAL:
        defined = 1'b1;
      default:
        defined = 1'b0;
    endcase
  end

  // Consecutive data-indicator zeros, saturating at the limit
  always_comb
  begin
    if (rx_dm)
      dm0_next = 2'h0;
    else if (q.dm0_cnt == `EOCP_DM0_LIMIT)
      dm0_next = q.dm0_cnt;
    else
      dm0_next = q.dm0_cnt + 2'h1;
  end

  eocp_three_look u_look
  (
    .clk         (clk),
    .rst         (rst),
    .msg_valid   (rx_msg_valid),
    .msg         (rx_msg),
    .qualify     (look_ok),
    .qualify_new (look_new),
    .verified    (verified)
  );

  eocp_cmd_latch u_latch
  (
    .clk         (clk),
    .rst         (rst),
    .exec        (q.exec),
    .info        (q.exec_info),
    .analog_en   (q.exec_analog),
    .deactivate  (deactivate),
    .state       (latch)
  );

  // Next state of the processor
  always_comb
  begin
    d        = q;
    d.report = 1'b0;
    d.exec   = 1'b0;

    // Software writes; transmit value is taken in every mode
    if (reg_wr)
    begin
      if (reg_addr == `EOCP_REG_MODE)
        d.mode = eocp_mode_t'(reg_wdata[1:0]);
      if (sw_tx_wr)
        d.tx = reg_wdata[11:0];
    end

    if (rx_msg_valid)
    begin
      d.rx      = rx_msg;
      d.rx_seen = 1'b1;
      d.dm0_cnt = dm0_next;

      unique case (q.mode)
        EOCP_AUTO:
        begin
          // Answer goes out at once; the automatic answer beats a software write
          if (!addr_ok)
            d.tx = `EOCP_HOLD_MSG;
          else if ((dm0_next == `EOCP_DM0_LIMIT) || (rx_dm && !defined && look_ok))
            d.tx = `EOCP_NO_COMPLY_MSG;
          else if (look_new && rx_dm && (rx_info == `EOCP_CMD_NORMAL))
            d.tx = `EOCP_TX_RESET;
          else
            d.tx = rx_msg;
          d.report = look_new;
          // Execute only verified, addressed messages
          if (look_new && addr_ok && rx_dm && defined)
          begin
            d.exec      = 1'b1;
            d.exec_info = rx_info;
            d.exec_analog = 1'b1;
          end
        end
        EOCP_PERIODIC:
          d.report = 1'b1;
        EOCP_ONCHANGE:
          d.report = !q.rx_seen || (rx_msg != q.rx);
        EOCP_THREELOOK:
          d.report = look_ok;
      endcase
      // Transparent modes never execute
    end

    // Read data stand in the cycle after the strobe only
    d.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        `EOCP_REG_MODE:
          d.rdata = {30'h0, q.mode};
        `EOCP_REG_TX:
          d.rdata = {20'h0, q.tx};
        `EOCP_REG_RX:
          d.rdata = {20'h0, q.rx};
        `EOCP_REG_VERIFIED:
          d.rdata = {20'h0, verified};
        `EOCP_REG_STATUS:
          d.rdata = {21'h0, q.dm0_cnt, latch};
        default:
          d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q      <= '0;
      q.mode <= EOCP_AUTO;
      q.tx   <= `EOCP_TX_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata               = q.rdata;
  assign tx_msg                  = q.tx;
  assign rx_report               = q.report;
  assign full_loopback_cmd       = latch.full_loop;
  assign analog_loop_request_ind = latch.analog_req;
  assign bearer1_loopback        = latch.b1;
  assign bearer2_loopback        = latch.b2;
  assign loop_side_select        = latch.side_sel;
  assign crc_invert              = latch.crc_inv;
  assign febe_count_stop         = latch.febe_stop;
  assign nebe_count_stop         = latch.nebe_stop;
  assign err_ind_hold            = latch.err_hold;

endmodule
`default_nettype wire
